// [design/ees_pkg.sv]
// Constants and types shared by the serial EEPROM slave protocol engine.
package ees_pkg;

    // ------------------------------------------------------------------
    // Clocks and timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ = 40;
    localparam int LINK_PERIOD_NS = 12;
    localparam int FILTER_NS = 50;
    // A least time: round up to whole sampling-clock cycles.
    localparam int FILTER_CYCLES = (FILTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int WRITE_CYCLE_US = 10000;
    localparam int WRITE_CYCLES = WRITE_CYCLE_US * CLOCK_MHZ;

    typedef logic [19:0] ees_wcount_type;
    typedef logic [2:0] ees_fcount_type;
    localparam ees_fcount_type FILTER_LAST = ees_fcount_type'(FILTER_CYCLES - 1);

    // ------------------------------------------------------------------
    // Memory geometry and addressing
    // ------------------------------------------------------------------
    localparam int MEM_BYTES = 512;
    localparam int ADDR_BITS = 9;
    localparam int PAGE_BYTES = 8;
    localparam int PAGE_BITS = 3;
    typedef logic [ADDR_BITS-1:0] ees_addr_type;
    typedef logic [PAGE_BITS-1:0] ees_page_index_type;
    localparam ees_addr_type ADDR_ONE = 9'h001;
    localparam ees_page_index_type PAGE_ONE = 3'h1;

    // ------------------------------------------------------------------
    // Slave address byte
    // ------------------------------------------------------------------
    localparam logic [3:0] DEVICE_CODE = 4'ha;
    localparam logic [2:0] SLAVE_CODE_RESET = 3'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_COUNT_ONE = 4'h1;
    localparam logic RW_READ = 1'h1;

    // ------------------------------------------------------------------
    // Protocol states and received-byte phases
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RECV = 6'h02,
        ST_ACK = 6'h04,
        ST_SEND = 6'h08,
        ST_MACK = 6'h10,
        ST_BUSY = 6'h20
    } ees_state_type;

    typedef enum logic [3:0] {
        PH_DEV = 4'h1,
        PH_ADDR_HI = 4'h2,
        PH_ADDR_LO = 4'h4,
        PH_DATA = 4'h8
    } ees_phase_type;

endpackage : ees_pkg

// [design/ees_eeprom_slave.sv]
// Slave-side protocol engine of a 512-byte serial EEPROM on a two-wire bus.
// Notes on behaviour
// - Matching address with write direction gets a low ack, then write mode.
// - Two memory address bytes arrive upper first, each MSB first.
// - Each memory address byte and each write data byte gets a low ack.
// - Stop after write data starts the timed write; pins ignored until done.
// - One write cycle commits one to eight bytes of a single page.
// - Each further data byte advances only the three low address bits.
// - Low address bits wrap inside the page; last byte per location wins.
// - Stop during page write ends reception and writes the buffered bytes.
// - Polling address gets ack high while writing, ack low once finished.
// - Busy shows only after the stop that ends the write data.
// - Reads start like writes but with the direction bit at one.
// - Address counter holds last accessed address plus one for current reads.
// - Current read acks the address low then sends one byte MSB first.
// - Master ends a read with ack high then stop; device goes to standby.
// - A read that reached the final address leaves the counter at zero.
// - A write that reached a page end leaves the counter at page start.
// - Dummy write of both address bytes then repeated start reads from it.
// - Master ack low after a read byte advances the address and sends more.
// - Sequential read wraps from the final address to zero and continues.
// - Pulses on SCL or SDA narrower than the filter width are rejected.
// - Wrong device code or slave code after start sends the device to standby.
// - Without master ack low or stop after read data, bus stays released.
`timescale 1ns/10ps
`default_nettype none

module ees_eeprom_slave #(
    parameter int WRITE_CYCLES = ees_pkg::WRITE_CYCLES
) (
    // System clock domain
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    // Bus sampling clock domain
    input wire logic sampleClock,
    // Two-wire bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOutEnable,
    // Slave address strap and status
    input wire logic [2:0] slaveAddressCode,
    output logic writeBusy
);

    // ------------------------------------------------------------------
    // Reset and enable into the sampling domain
    // ------------------------------------------------------------------
    logic [1:0] rstSync_reg;
    logic [1:0] ceSync_reg;
    logic linkRstN;
    logic linkCe;

    always_ff @(posedge sampleClock) begin
        rstSync_reg <= {rstSync_reg[0], rst_n};
        ceSync_reg <= {ceSync_reg[0], clockEnable};
    end
    assign linkRstN = rstSync_reg[1];
    assign linkCe = ceSync_reg[1];

    // ------------------------------------------------------------------
    // Input synchronisers and glitch filters
    // ------------------------------------------------------------------
    logic [1:0] pinRaw;
    logic [1:0] pinFilt;
    logic [1:0] pinPrev_reg;

    assign pinRaw = {sdaIn, sclIn};

    for (genvar i = 0; i < 2; i++) begin : g_filter
        logic sync1_reg;
        logic sync2_reg;
        logic filt_reg;
        ees_pkg::ees_fcount_type count_reg;

        always_ff @(posedge sampleClock) begin
            sync1_reg <= pinRaw[i];
            sync2_reg <= sync1_reg;
        end

        // A level must differ for the full filter width before it is taken.
        always_ff @(posedge sampleClock) begin
            if (!linkRstN) begin
                filt_reg <= 1'b1;
                count_reg <= '0;
            end else if (linkCe) begin
                if (sync2_reg == filt_reg) begin
                    count_reg <= '0;
                end else if (count_reg == ees_pkg::FILTER_LAST) begin
                    filt_reg <= sync2_reg;
                    count_reg <= '0;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
        assign pinFilt[i] = filt_reg;
    end

    always_ff @(posedge sampleClock) begin
        if (!linkRstN) begin
            pinPrev_reg <= 2'h3;
        end else if (linkCe) begin
            pinPrev_reg <= pinFilt;
        end
    end

    logic sclF;
    logic sdaF;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    assign sclF = pinFilt[0];
    assign sdaF = pinFilt[1];
    assign sclRise = sclF && !pinPrev_reg[0];
    assign sclFall = !sclF && pinPrev_reg[0];
    assign startCond = sclF && pinPrev_reg[0] && pinPrev_reg[1] && !sdaF;
    assign stopCond = sclF && pinPrev_reg[0] && !pinPrev_reg[1] && sdaF;

    // ------------------------------------------------------------------
    // Slave address strap, caught once after reset release
    // ------------------------------------------------------------------
    logic [2:0] strapSync1_reg;
    logic [2:0] strapSync2_reg;
    logic strapTaken_reg;
    logic [2:0] slave_address_compare_reg;

    always_ff @(posedge sampleClock) begin
        strapSync1_reg <= slaveAddressCode;
        strapSync2_reg <= strapSync1_reg;
    end

    always_ff @(posedge sampleClock) begin
        if (!linkRstN) begin
            strapTaken_reg <= 1'b0;
            slave_address_compare_reg <= ees_pkg::SLAVE_CODE_RESET;
        end else if (linkCe && !strapTaken_reg) begin
            strapTaken_reg <= 1'b1;
            slave_address_compare_reg <= strapSync2_reg;
        end
    end

    // ------------------------------------------------------------------
    // Write-cycle handshake with the system domain
    // ------------------------------------------------------------------
    logic writeReqTgl_reg;
    logic ackSync1_reg;
    logic ackSync2_reg;
    logic writeAckTgl_reg;
    logic cycleRunning;

    always_ff @(posedge sampleClock) begin
        ackSync1_reg <= writeAckTgl_reg;
        ackSync2_reg <= ackSync1_reg;
    end
    assign cycleRunning = writeReqTgl_reg != ackSync2_reg;

    // ------------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------------
    ees_pkg::ees_state_type state_reg;
    ees_pkg::ees_phase_type phase_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] rxShift_reg;
    logic [7:0] txShift_reg;
    logic readDir_reg;
    logic sdaOutEnable_reg;
    logic sdaOut_reg;
    ees_pkg::ees_addr_type addrPtr_reg;
    logic [7:0] pageBuf_reg [ees_pkg::PAGE_BYTES];
    logic [ees_pkg::PAGE_BYTES-1:0] pageValid_reg;
    logic [7:0] memArray [ees_pkg::MEM_BYTES];

    logic byteDone;
    logic devMatch;
    logic dataByte;
    logic commitNow;
    logic loadRead;
    logic [7:0] memRdByte;

    assign byteDone = state_reg == ees_pkg::ST_RECV && sclFall
        && bitCnt_reg == ees_pkg::BITS_PER_BYTE;
    assign devMatch = rxShift_reg[7:4] == ees_pkg::DEVICE_CODE
        && rxShift_reg[3:1] == slave_address_compare_reg;
    assign dataByte = byteDone && phase_reg == ees_pkg::PH_DATA;
    assign commitNow = stopCond && state_reg == ees_pkg::ST_RECV
        && phase_reg == ees_pkg::PH_DATA && pageValid_reg != '0;
    assign loadRead = (byteDone && phase_reg == ees_pkg::PH_DEV && devMatch
        && rxShift_reg[0] == ees_pkg::RW_READ)
        || (state_reg == ees_pkg::ST_MACK && sclRise && !sdaF);
    assign memRdByte = memArray[addrPtr_reg];

    // ------------------------------------------------------------------
    // Bit-level sequencing and the SDA driver
    // ------------------------------------------------------------------
    always_ff @(posedge sampleClock) begin
        if (!linkRstN) begin
            state_reg <= ees_pkg::ST_IDLE;
            phase_reg <= ees_pkg::PH_DEV;
            bitCnt_reg <= '0;
            rxShift_reg <= '0;
            txShift_reg <= '0;
            readDir_reg <= 1'b0;
            sdaOutEnable_reg <= 1'b0;
            sdaOut_reg <= 1'b0;
            writeReqTgl_reg <= 1'b0;
        end else if (linkCe) begin
            if (state_reg == ees_pkg::ST_BUSY) begin
                // Pins are ignored, so a polling address sees ack high.
                if (!cycleRunning) begin
                    state_reg <= ees_pkg::ST_IDLE;
                end
            end else if (startCond) begin
                state_reg <= ees_pkg::ST_RECV;
                phase_reg <= ees_pkg::PH_DEV;
                bitCnt_reg <= '0;
                sdaOutEnable_reg <= 1'b0;
            end else if (stopCond) begin
                sdaOutEnable_reg <= 1'b0;
                if (commitNow) begin
                    state_reg <= ees_pkg::ST_BUSY;
                    writeReqTgl_reg <= !writeReqTgl_reg;
                end else begin
                    state_reg <= ees_pkg::ST_IDLE;
                end
            end else begin
                unique case (state_reg)
                    ees_pkg::ST_IDLE: begin
                        sdaOutEnable_reg <= 1'b0;
                    end
                    ees_pkg::ST_RECV: begin
                        if (sclRise && bitCnt_reg != ees_pkg::BITS_PER_BYTE) begin
                            rxShift_reg <= {rxShift_reg[6:0], sdaF};
                            bitCnt_reg <= bitCnt_reg + ees_pkg::BIT_COUNT_ONE;
                        end else if (byteDone) begin
                            if (phase_reg == ees_pkg::PH_DEV && !devMatch) begin
                                state_reg <= ees_pkg::ST_IDLE;
                            end else begin
                                sdaOutEnable_reg <= 1'b1;
                                state_reg <= ees_pkg::ST_ACK;
                                if (phase_reg == ees_pkg::PH_DEV) begin
                                    readDir_reg <= rxShift_reg[0];
                                    phase_reg <= ees_pkg::PH_ADDR_HI;
                                    txShift_reg <= memRdByte;
                                end else if (phase_reg == ees_pkg::PH_ADDR_HI) begin
                                    phase_reg <= ees_pkg::PH_ADDR_LO;
                                end else begin
                                    phase_reg <= ees_pkg::PH_DATA;
                                end
                            end
                        end
                    end
                    ees_pkg::ST_ACK: begin
                        if (sclFall) begin
                            if (readDir_reg) begin
                                // The first data bit leaves on the falling edge ending ack.
                                sdaOutEnable_reg <= !txShift_reg[7];
                                txShift_reg <= {txShift_reg[6:0], 1'b0};
                                bitCnt_reg <= ees_pkg::BIT_COUNT_ONE;
                                state_reg <= ees_pkg::ST_SEND;
                            end else begin
                                sdaOutEnable_reg <= 1'b0;
                                bitCnt_reg <= '0;
                                state_reg <= ees_pkg::ST_RECV;
                            end
                        end
                    end
                    ees_pkg::ST_SEND: begin
                        if (sclFall) begin
                            if (bitCnt_reg == ees_pkg::BITS_PER_BYTE) begin
                                sdaOutEnable_reg <= 1'b0;
                                state_reg <= ees_pkg::ST_MACK;
                            end else begin
                                sdaOutEnable_reg <= !txShift_reg[7];
                                txShift_reg <= {txShift_reg[6:0], 1'b0};
                                bitCnt_reg <= bitCnt_reg + ees_pkg::BIT_COUNT_ONE;
                            end
                        end
                    end
                    ees_pkg::ST_MACK: begin
                        if (sclRise) begin
                            if (!sdaF) begin
                                txShift_reg <= memRdByte;
                                bitCnt_reg <= '0;
                                state_reg <= ees_pkg::ST_SEND;
                            end else begin
                                // Nothing more is sent until a new start arrives.
                                state_reg <= ees_pkg::ST_IDLE;
                            end
                        end
                    end
                    ees_pkg::ST_BUSY: begin
                        state_reg <= ees_pkg::ST_BUSY;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Address counter and page buffer
    // ------------------------------------------------------------------
    always_ff @(posedge sampleClock) begin
        if (!linkRstN) begin
            addrPtr_reg <= '0;
            pageValid_reg <= '0;
        end else if (linkCe) begin
            if (byteDone && phase_reg == ees_pkg::PH_ADDR_HI) begin
                addrPtr_reg[ees_pkg::ADDR_BITS-1] <= rxShift_reg[0];
            end else if (byteDone && phase_reg == ees_pkg::PH_ADDR_LO) begin
                addrPtr_reg[7:0] <= rxShift_reg;
                pageValid_reg <= '0;
            end else if (dataByte) begin
                // Only the in-page bits move, so a page end wraps to its start.
                pageBuf_reg[addrPtr_reg[ees_pkg::PAGE_BITS-1:0]] <= rxShift_reg;
                pageValid_reg[addrPtr_reg[ees_pkg::PAGE_BITS-1:0]] <= 1'b1;
                addrPtr_reg[ees_pkg::PAGE_BITS-1:0] <=
                    addrPtr_reg[ees_pkg::PAGE_BITS-1:0] + ees_pkg::PAGE_ONE;
            end else if (loadRead) begin
                addrPtr_reg <= addrPtr_reg + ees_pkg::ADDR_ONE;
            end else if (commitNow) begin
                pageValid_reg <= '0;
            end
        end
    end

    // Only the buffered page bytes are written at the stop; the timed cycle only holds off the bus.
    always_ff @(posedge sampleClock) begin
        if (linkCe && linkRstN && commitNow) begin
            for (int j = 0; j < ees_pkg::PAGE_BYTES; j++) begin
                if (pageValid_reg[j]) begin
                    memArray[{addrPtr_reg[ees_pkg::ADDR_BITS-1:ees_pkg::PAGE_BITS],
                        ees_pkg::ees_page_index_type'(j)}] <= pageBuf_reg[j];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Timed write cycle in the system domain
    // ------------------------------------------------------------------
    logic reqSync1_reg;
    logic reqSync2_reg;
    logic reqSeen_reg;
    logic writeBusy_reg;
    ees_pkg::ees_wcount_type writeCount_reg;

    always_ff @(posedge clock) begin
        reqSync1_reg <= writeReqTgl_reg;
        reqSync2_reg <= reqSync1_reg;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reqSeen_reg <= 1'b0;
            writeAckTgl_reg <= 1'b0;
            writeBusy_reg <= 1'b0;
            writeCount_reg <= '0;
        end else if (clockEnable) begin
            if (!writeBusy_reg && reqSync2_reg != reqSeen_reg) begin
                reqSeen_reg <= reqSync2_reg;
                writeBusy_reg <= 1'b1;
                writeCount_reg <= ees_pkg::ees_wcount_type'(WRITE_CYCLES - 1);
            end else if (writeBusy_reg) begin
                if (writeCount_reg == '0) begin
                    writeBusy_reg <= 1'b0;
                    writeAckTgl_reg <= reqSeen_reg;
                end else begin
                    writeCount_reg <= writeCount_reg - 1'b1;
                end
            end
        end
    end

    assign sdaOut = sdaOut_reg;
    assign sdaOutEnable = sdaOutEnable_reg;
    assign writeBusy = writeBusy_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_device_ack: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && byteDone && phase_reg == ees_pkg::PH_DEV && devMatch && !stopCond
        |=> sdaOutEnable_reg && state_reg == ees_pkg::ST_ACK
            && phase_reg == ees_pkg::PH_ADDR_HI)
        else $error("Matching address byte not acknowledged.");

    a_address_mismatch: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && byteDone && phase_reg == ees_pkg::PH_DEV && !devMatch && !stopCond
        |=> state_reg == ees_pkg::ST_IDLE && !sdaOutEnable_reg)
        else $error("Foreign address byte did not send the device to standby.");

    a_byte_ack: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && byteDone && phase_reg != ees_pkg::PH_DEV && !stopCond
        |=> sdaOutEnable_reg)
        else $error("Address or data byte not acknowledged.");

    a_low_address: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && byteDone && phase_reg == ees_pkg::PH_ADDR_LO && !stopCond
        |=> addrPtr_reg[7:0] == $past(rxShift_reg))
        else $error("Lower memory address byte not captured.");

    a_page_wrap: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && dataByte && !stopCond
        |=> addrPtr_reg[8:3] == $past(addrPtr_reg[8:3])
            && addrPtr_reg[2:0] == $past(addrPtr_reg[2:0]) + ees_pkg::PAGE_ONE)
        else $error("Page write address left its page or did not advance.");

    a_read_advance: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && loadRead && !startCond && !stopCond
        |=> addrPtr_reg == $past(addrPtr_reg) + ees_pkg::ADDR_ONE)
        else $error("Read address counter did not advance by one.");

    a_stop_busy: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && commitNow
        |=> state_reg == ees_pkg::ST_BUSY ##1 cycleRunning)
        else $error("Stop after write data did not start the write cycle.");

    a_busy_released: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        state_reg == ees_pkg::ST_BUSY |-> !sdaOutEnable_reg)
        else $error("Bus driven during the write cycle.");

    a_master_nack: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && state_reg == ees_pkg::ST_MACK && sclRise && sdaF && !stopCond
        |=> state_reg == ees_pkg::ST_IDLE && !sdaOutEnable_reg)
        else $error("Data sent after master returned ack high.");

    a_tx_bit: assert property (@(posedge sampleClock) disable iff (!linkRstN)
        linkCe && state_reg == ees_pkg::ST_SEND && sclFall && !startCond && !stopCond
            && bitCnt_reg != ees_pkg::BITS_PER_BYTE
        |=> sdaOutEnable_reg == !$past(txShift_reg[7]))
        else $error("Read data bit not driven MSB first.");

endmodule : ees_eeprom_slave

`default_nettype wire

// [dv/ees_bus_master.sv]
// Bus master model that drives the clock and data wires of the two-wire link.
`timescale 1ns/10ps
`default_nettype none
module ees_bus_master (
    // Bus wires
    output logic scl,
    output logic sdaDrive,
    input wire logic sdaWire
);
    // The high clock phase spans 25 sampling periods and the low one 35, well above the filter delay.
    localparam int HALF = 300;
    initial {scl, sdaDrive} = 2'b11;
    task automatic frame_edge(input logic isStart);
        #120 sdaDrive = isStart;
        #HALF scl = 1'b1;
        #HALF sdaDrive = ~isStart;
        #HALF scl = ~isStart;
    endtask : frame_edge
    // A pulse narrower than the filter width while the clock rests low.
    task automatic spike(input int width);
        #120 scl = 1'b1;
        #width scl = 1'b0;
    endtask : spike
    // Data moves a margin after the clock falls, so it never changes with the clock high.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #120 sdaDrive = tx[i];
            #HALF scl = 1'b1;
            #HALF rx[i] = sdaWire;
            scl = 1'b0;
        end
    endtask : xfer
endmodule : ees_bus_master
`default_nettype wire

// [dv/serial_eeprom_slave_protocol_tb.sv]
// Self-checking bench for the serial EEPROM slave protocol engine.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_slave_protocol_tb;
    logic clock = 1'b0, sampleClock = 1'b0, rst_n = 1'b0;
    logic masterScl, masterSda, sdaOut, sdaOutEnable, writeBusy;
    logic ce = 1'b1;
    logic [2:0] strap;
    logic [7:0] mem [512];
    int num_errors = 0, checks = 0, seed = 32'he407;
    initial forever #12.5 clock = ~clock;
    initial #3 forever #6 sampleClock = ~sampleClock;
    // The wire is pulled up, so it reads low whenever either side pulls it.
    wire logic sdaLine = sdaOutEnable ? 1'b0 : masterSda;
    // The write cycle outlasts a whole polling header, so that poll sees ack high while busy.
    ees_eeprom_slave #(.WRITE_CYCLES(600)) dut (.clock(clock), .rst_n(rst_n),
        .clockEnable(ce), .sampleClock(sampleClock), .sclIn(masterScl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOutEnable(sdaOutEnable), .slaveAddressCode(strap),
        .writeBusy(writeBusy));
    ees_bus_master bm (.scl(masterScl), .sdaDrive(masterSda), .sdaWire(sdaLine));
    // With the slave silent the master reads back its own levels.
    task automatic io(input logic [8:0] tx, input logic [8:0] exp);
        logic [8:0] rx;
        bm.xfer(tx, rx);
        checks++;
        if (rx !== exp || sdaOut !== 1'b0) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, rx, exp);
        end
    endtask : io
    function automatic logic [8:0] hdr(input logic rw);
        return {4'ha, strap, rw, 1'b1};
    endfunction : hdr
    function automatic logic [8:0] ackd(input logic [8:0] v);
        return {v[8:1], 1'b0};
    endfunction : ackd
    task automatic check_busy(input logic exp);
        checks++;
        if (writeBusy !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: writeBusy %b, expected %b", $time, writeBusy, exp);
        end
    endtask : check_busy
    // A clock spike after the header would shift an extra bit if the filter let it through.
    task automatic set_addr(input logic [8:0] a);
        bm.frame_edge(1'b1);
        io(hdr(1'b0), ackd(hdr(1'b0)));
        bm.spike(36);
        io({7'h0, a[8], 1'b1}, {7'h0, a[8], 1'b0});
        io({a[7:0], 1'b1}, {a[7:0], 1'b0});
    endtask : set_addr
    task automatic write_page(input logic [8:0] a, input int n, input logic freeze);
        logic [7:0] d;
        logic [2:0] idx;
        idx = a[2:0];
        set_addr(a);
        repeat (n) begin
            d = 8'($random(seed));
            mem[{a[8:3], idx}] = d;
            io({d, 1'b1}, {d, 1'b0});
            idx++;
        end
        bm.frame_edge(1'b0);
        bm.frame_edge(1'b1);
        io(hdr(1'b0), hdr(1'b0));
        check_busy(1'b1);
        bm.frame_edge(1'b0);
        if (freeze) begin
            @(posedge clock);
            #2 ce = 1'b0;
            repeat (700) @(posedge clock);
            #2 check_busy(1'b1);
            ce = 1'b1;
        end
        for (int i = 0; i < 1000 && writeBusy !== 1'b0; i++) @(negedge clock);
        check_busy(1'b0);
        repeat (10) @(posedge sampleClock);
        bm.frame_edge(1'b1);
        io(hdr(1'b0), ackd(hdr(1'b0)));
        bm.frame_edge(1'b0);
    endtask : write_page
    task automatic wrap_up();
        if (num_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        strap = 3'($random(seed));
        repeat (6) @(posedge clock);
        #2 rst_n = 1'b1;
        repeat (20) @(posedge sampleClock);
        write_page(9'h1fe, 10, 1'b1);
        write_page(9'h003, 13, 1'b0);
        bm.frame_edge(1'b1);
        io(hdr(1'b1), ackd(hdr(1'b1)));
        io(9'h1ff, {mem[9'h000], 1'b1});
        bm.frame_edge(1'b0);
        set_addr(9'h1fe);
        bm.frame_edge(1'b1);
        io(hdr(1'b1), ackd(hdr(1'b1)));
        for (int i = 0; i < 4; i++) io({8'hff, i == 3}, {mem[9'(9'h1fe + i)], i == 3});
        io(9'h1ff, 9'h1ff);
        bm.frame_edge(1'b0);
        set_addr(9'h1ff);
        bm.frame_edge(1'b1);
        io(hdr(1'b1), ackd(hdr(1'b1)));
        io(9'h1ff, {mem[9'h1ff], 1'b1});
        bm.frame_edge(1'b0);
        bm.frame_edge(1'b1);
        io(hdr(1'b1), ackd(hdr(1'b1)));
        io(9'h1ff, {mem[9'h000], 1'b1});
        bm.frame_edge(1'b0);
        bm.frame_edge(1'b1);
        io({4'ha, ~strap, 2'b01}, {4'ha, ~strap, 2'b01});
        bm.frame_edge(1'b0);
        wrap_up();
    end
    initial begin
        #1_000_000 num_errors++;
        wrap_up();
    end
endmodule : serial_eeprom_slave_protocol_tb
`default_nettype wire
